// >>> rtl/sys_cfg_pkg.sv
// Constants for the system configuration register bank
package sys_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] SYSTEM_CONFIG_PRIMARY_ADDR   = 6'h00;
  localparam logic [5:0] FAULT_RESPONSE_CONFIG_ADDR   = 6'h01;
  localparam logic [5:0] COMM_WATCHDOG_TAP_ADDR       = 6'h02;
  localparam logic [5:0] DEVICE_RESET_REG_ADDR        = 6'h2e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONFIG_PRIMARY_RESET  = 8'h10;
  localparam logic [7:0] FAULT_RESPONSE_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] COMM_WATCHDOG_TAP_RESET      = 8'h08;
  localparam logic [7:0] DEVICE_RESET_REG_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions in system_config_primary
  // ----------------------------------------------------------------
  localparam int CHAN1_ENABLE_BIT          = 0;
  localparam int CHAN1_INTERNAL_DIM_BIT    = 1;
  localparam int CHAN2_ENABLE_BIT          = 2;
  localparam int CHAN2_INTERNAL_DIM_BIT    = 3;
  localparam int COMM_WATCHDOG_ENABLE_BIT  = 4;
  localparam int SOFTWARE_LIMP_HOME_BIT    = 5;
  localparam int DIM_PHASE_SELECT_BIT      = 6;
  localparam int FAULT_OUTPUT_RELEASE_BIT  = 7;

  // Latched-response bits in fault_response_config: ls, hs, thermal
  localparam int CHAN1_LATCH_LSB           = 0;
  localparam int CHAN2_LATCH_LSB           = 3;

  // Watchdog: 25-bit counter, taps 16..24, tap field 4 bits
  localparam int          WATCHDOG_WIDTH   = 25;
  localparam int          WATCHDOG_TAP_MIN = 16;
  localparam logic [3:0]  WATCHDOG_TAP_MAX = 4'h8;
  localparam int          TAP_FIELD_MASK_W = 4;

endpackage : sys_cfg_pkg

// >>> rtl/comm_watchdog.sv
// Communication watchdog with selectable timeout tap
`timescale 1ns/1ps
`default_nettype none

module comm_watchdog
(
  input  wire logic       clk_in,       // System clock
  input  wire logic       rst_in,       // Async reset, active high
  input  wire logic       enable_in,    // Watchdog enabled
  input  wire logic       kick_in,      // Valid host access seen
  input  wire logic [3:0] tap_in,       // Tap select field
  output logic            timeout_out   // One-cycle timeout pulse
);

  logic [sys_cfg_pkg::WATCHDOG_WIDTH-1:0] count;
  logic [sys_cfg_pkg::WATCHDOG_WIDTH-1:0] next_count;
  logic                                   next_timeout;
  logic [3:0]                             tap_eff;

  // --------------------------------------------------------------
  // Tap decode and counting
  // --------------------------------------------------------------
  always_comb
  begin
    // Codes above the highest tap all map to bit 24
    tap_eff = (tap_in > sys_cfg_pkg::WATCHDOG_TAP_MAX) ? sys_cfg_pkg::WATCHDOG_TAP_MAX : tap_in;
    next_timeout = 1'b0;
    next_count   = count;
    if (!enable_in || kick_in)
    begin
      next_count = '0;
    end
    else if (count[sys_cfg_pkg::WATCHDOG_TAP_MIN + int'(tap_eff)])
    begin
      // Restart after firing so a silent host keeps limp-home asserted
      next_timeout = 1'b1;
      next_count   = '0;
    end
    else
    begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count       <= '0;
      timeout_out <= 1'b0;
    end
    else
    begin
      count       <= next_count;
      timeout_out <= next_timeout;
    end
  end

endmodule : comm_watchdog

`default_nettype wire

// >>> rtl/system_config_regs.sv
// System configuration register bank of a dual-channel LED driver
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Configuration registers 0x00-0x02 are read/write
// - Primary configuration resets to 0x10
// - Release bit frees fault output if faultless
// - Release bit reads back as zero
// - Bit 6 chooses 180 or 0 degree phase
// - Writing limp-home bit enters limp-home state
// - Communication failure sets limp-home bit itself
// - Limp-home persists until host writes zero
// - Bit 4 enables watchdog, resets enabled
// - Bit 3 selects channel 2 dim source
// - Bit 1 selects channel 1 dim source
// - Bit 2 enables channel 2, resets off
// - Bit 0 enables channel 1, resets off
// - Latched fault clears channel enable bit
// - Watchdog is 25-bit, tap defaults bit 24
module system_config_regs
(
  input  wire logic       clk_in,                  // System clock, 100 MHz
  input  wire logic       rst_in,                  // Async reset, active high
  input  wire logic       wr_en_in,                // Register write strobe
  input  wire logic       rd_en_in,                // Register read strobe
  input  wire logic [5:0] addr_in,                 // Register offset
  input  wire logic [7:0] wr_data_in,              // Write data
  input  wire logic       fault_active_in,         // Any fault active
  input  wire logic       fault_set_in,            // Fault event sets fault output
  input  wire logic [2:0] chan1_fault_in,          // Ch1 faults: ls, hs, thermal
  input  wire logic [2:0] chan2_fault_in,          // Ch2 faults: ls, hs, thermal
  output logic [7:0]      rd_data_out,             // Read data, valid after rd_en
  output logic            chan1_enable_out,        // Channel 1 enabled
  output logic            chan2_enable_out,        // Channel 2 enabled
  output logic            chan1_internal_dim_out,  // Ch1 uses internal dimming
  output logic            chan2_internal_dim_out,  // Ch2 uses internal dimming
  output logic            dim_phase_select_out,    // 1 = 0 deg, 0 = 180 deg
  output logic            limp_home_out,           // Limp-home state
  output logic            fault_output_on_out,     // Drive open-drain fault low
  output logic [7:0]      fault_response_out,      // Fault response config
  output logic [3:0]      watchdog_tap_out,        // Watchdog tap field
  output logic [7:0]      device_reset_reg_out     // Reset register contents
);

  logic [6:0] primary;
  logic [6:0] next_primary;
  logic [7:0] fault_cfg;
  logic [7:0] next_fault_cfg;
  logic [3:0] tap_sel;
  logic [3:0] next_tap_sel;
  logic [7:0] reset_reg;
  logic [7:0] next_reset_reg;
  logic       fault_pin;
  logic       next_fault_pin;
  logic [7:0] next_rd_data;
  logic [2:0] f1_meta;
  logic [2:0] f1_sync;
  logic [2:0] f2_meta;
  logic [2:0] f2_sync;
  logic [1:0] fa_meta;
  logic [1:0] fa_sync;
  logic       wd_timeout;

  // Write hit on a given offset
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction : hit

  // Any enabled latched-response fault for a channel
  function automatic logic latch_off(input logic [2:0] f, input logic [2:0] cfg);
    latch_off = |(f & cfg);
  endfunction : latch_off

  // --------------------------------------------------------------
  // Fault input synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      f1_meta <= 3'h0;
      f1_sync <= 3'h0;
      f2_meta <= 3'h0;
      f2_sync <= 3'h0;
      fa_meta <= 2'h0;
      fa_sync <= 2'h0;
    end
    else
    begin
      f1_meta <= chan1_fault_in;
      f1_sync <= f1_meta;
      f2_meta <= chan2_fault_in;
      f2_sync <= f2_meta;
      fa_meta <= {fault_set_in, fault_active_in};
      fa_sync <= fa_meta;
    end
  end

  // --------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------
  comm_watchdog u_watchdog
  (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .enable_in   (primary[sys_cfg_pkg::COMM_WATCHDOG_ENABLE_BIT]),
    .kick_in     (wr_en_in | rd_en_in),
    .tap_in      (tap_sel),
    .timeout_out (wd_timeout)
  );

  // --------------------------------------------------------------
  // Register next-state
  // --------------------------------------------------------------
  always_comb
  begin
    next_primary   = primary;
    next_fault_cfg = fault_cfg;
    next_tap_sel   = tap_sel;
    next_reset_reg = reset_reg;
    next_fault_pin = fault_pin;
    if (wr_en_in)
    begin
      if (hit(addr_in, sys_cfg_pkg::SYSTEM_CONFIG_PRIMARY_ADDR))
      begin
        next_primary = wr_data_in[6:0];
        // Zero in the release bit leaves the fault output alone
        if (wr_data_in[sys_cfg_pkg::FAULT_OUTPUT_RELEASE_BIT] && !fa_sync[0])
        begin
          next_fault_pin = 1'b0;
        end
      end
      if (hit(addr_in, sys_cfg_pkg::FAULT_RESPONSE_CONFIG_ADDR))
      begin
        next_fault_cfg = wr_data_in;
      end
      if (hit(addr_in, sys_cfg_pkg::COMM_WATCHDOG_TAP_ADDR))
      begin
        next_tap_sel = wr_data_in[sys_cfg_pkg::TAP_FIELD_MASK_W-1:0];
      end
      if (hit(addr_in, sys_cfg_pkg::DEVICE_RESET_REG_ADDR))
      begin
        next_reset_reg = wr_data_in;
      end
    end
    // Hardware events win over a simultaneous host write
    if (fa_sync[1])
    begin
      next_fault_pin = 1'b1;
    end
    if (wd_timeout)
    begin
      next_primary[sys_cfg_pkg::SOFTWARE_LIMP_HOME_BIT] = 1'b1;
    end
    if (latch_off(f1_sync, fault_cfg[sys_cfg_pkg::CHAN1_LATCH_LSB +: 3]))
    begin
      next_primary[sys_cfg_pkg::CHAN1_ENABLE_BIT] = 1'b0;
    end
    if (latch_off(f2_sync, fault_cfg[sys_cfg_pkg::CHAN2_LATCH_LSB +: 3]))
    begin
      next_primary[sys_cfg_pkg::CHAN2_ENABLE_BIT] = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  always_comb
  begin
    next_rd_data = rd_data_out;
    if (rd_en_in)
    begin
      case (addr_in)
        sys_cfg_pkg::SYSTEM_CONFIG_PRIMARY_ADDR: next_rd_data = {1'b0, primary};
        sys_cfg_pkg::FAULT_RESPONSE_CONFIG_ADDR: next_rd_data = fault_cfg;
        sys_cfg_pkg::COMM_WATCHDOG_TAP_ADDR:     next_rd_data = {4'h0, tap_sel};
        sys_cfg_pkg::DEVICE_RESET_REG_ADDR:      next_rd_data = reset_reg;
        default:                                 next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      primary     <= sys_cfg_pkg::SYSTEM_CONFIG_PRIMARY_RESET[6:0];
      fault_cfg   <= sys_cfg_pkg::FAULT_RESPONSE_CONFIG_RESET;
      tap_sel     <= sys_cfg_pkg::COMM_WATCHDOG_TAP_RESET[3:0];
      reset_reg   <= sys_cfg_pkg::DEVICE_RESET_REG_RESET;
      fault_pin   <= 1'b0;
      rd_data_out <= 8'h00;
    end
    else
    begin
      primary     <= next_primary;
      fault_cfg   <= next_fault_cfg;
      tap_sel     <= next_tap_sel;
      reset_reg   <= next_reset_reg;
      fault_pin   <= next_fault_pin;
      rd_data_out <= next_rd_data;
    end
  end

  // --------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // --------------------------------------------------------------
  assign chan1_enable_out       = primary[sys_cfg_pkg::CHAN1_ENABLE_BIT];
  assign chan2_enable_out       = primary[sys_cfg_pkg::CHAN2_ENABLE_BIT];
  assign chan1_internal_dim_out = primary[sys_cfg_pkg::CHAN1_INTERNAL_DIM_BIT];
  assign chan2_internal_dim_out = primary[sys_cfg_pkg::CHAN2_INTERNAL_DIM_BIT];
  assign dim_phase_select_out   = primary[sys_cfg_pkg::DIM_PHASE_SELECT_BIT];
  assign limp_home_out          = primary[sys_cfg_pkg::SOFTWARE_LIMP_HOME_BIT];
  assign fault_output_on_out    = fault_pin;
  assign fault_response_out     = fault_cfg;
  assign watchdog_tap_out       = tap_sel;
  assign device_reset_reg_out   = reset_reg;

endmodule : system_config_regs

`default_nettype wire

// >>> test/host_model.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic       clk_in,     // Clock
  output logic            wr_en_out,  // Write strobe
  output logic            rd_en_out,  // Read strobe
  output logic [5:0]      addr_out,   // Offset
  output logic [7:0]      data_out    // Write data
);
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 6'h3f;
    data_out  = 8'h00;
  end

  // Idle bus shows inverted values, never the last one
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= w;
    rd_en_out <= !w;
    addr_out  <= a;
    data_out  <= (a == 6'h02) ? (d & 8'h0f) : d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    addr_out  <= ~a;
    data_out  <= ~d;
  endtask : access
endmodule : host_model
`default_nettype wire

// >>> test/system_config_regs_chk.sv
// Port checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_chk
(
  input wire logic       clk_in,                  // Clock
  input wire logic       rst_in,                  // Reset
  input wire logic       wr_en_in,                // Write
  input wire logic       rd_en_in,                // Read
  input wire logic [5:0] addr_in,                 // Offset
  input wire logic [7:0] wr_data_in,              // Data
  input wire logic [7:0] rd_data_out,             // Read data
  input wire logic       chan1_enable_out,        // Ch1 on
  input wire logic       chan2_enable_out,        // Ch2 on
  input wire logic       chan1_internal_dim_out,  // Ch1 dim
  input wire logic       chan2_internal_dim_out,  // Ch2 dim
  input wire logic       dim_phase_select_out,    // Phase
  input wire logic       limp_home_out,           // Limp
  input wire logic       fault_output_on_out,     // Fault pin
  input wire logic [7:0] fault_response_out,      // Reg 0x01
  input wire logic [7:0] device_reset_reg_out     // Reg 0x2e
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire w0 = wr_en_in && addr_in == 6'h00;
  wire um = !(addr_in inside {6'h00, 6'h01, 6'h02, 6'h2e});

  a_rd_bit_zero: assert property (rd_en_in && addr_in == 6'h00 |=> !rd_data_out[7])
    else $error("bit 7 read back set");
  a_unmapped_rd: assert property (rd_en_in && um |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_chan_enables: assert property (w0 && fault_response_out == 8'h00 |=>
    chan1_enable_out == $past(wr_data_in[0]) && chan2_enable_out == $past(wr_data_in[2]))
    else $error("channel enable mismatch");
  a_dim_select: assert property (w0 |=> chan1_internal_dim_out == $past(wr_data_in[1])
    && chan2_internal_dim_out == $past(wr_data_in[3])) else $error("dim select mismatch");
  a_phase_sel: assert property (w0 |=> dim_phase_select_out == $past(wr_data_in[6]))
    else $error("phase select mismatch");
  a_limp_enter: assert property (w0 && wr_data_in[5] |=> limp_home_out)
    else $error("limp write ignored");
  a_limp_hold: assert property (limp_home_out && !w0 |=> limp_home_out)
    else $error("limp left without write");
  a_reset_reg: assert property (wr_en_in && addr_in == 6'h2e |=>
    device_reset_reg_out == $past(wr_data_in)) else $error("reset register mismatch");
  a_fault_hold: assert property (fault_output_on_out && !(w0 && wr_data_in[7]) |=>
    fault_output_on_out) else $error("fault output dropped");

  c_release: cover property (w0 && wr_data_in[7]);
  c_limp_set: cover property ($rose(limp_home_out) && !$past(w0));
  c_fault_off: cover property ($fell(fault_output_on_out));
endmodule : cfg_regs_chk
`default_nettype wire

bind system_config_regs cfg_regs_chk chk (.clk_in(clk_in), .rst_in(rst_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .rd_data_out(rd_data_out), .chan1_enable_out(chan1_enable_out),
  .chan2_enable_out(chan2_enable_out), .chan1_internal_dim_out(chan1_internal_dim_out),
  .chan2_internal_dim_out(chan2_internal_dim_out), .limp_home_out(limp_home_out),
  .dim_phase_select_out(dim_phase_select_out), .fault_output_on_out(fault_output_on_out),
  .fault_response_out(fault_response_out), .device_reset_reg_out(device_reset_reg_out));

// >>> test/test_system_config_regs.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
module test_system_config_regs;
  logic        clk_in = 1'b0, rst_in = 1'b1, fa = 1'b0, fs = 1'b0, rv = 1'b0;
  logic        wr_en, rd_en, ch1, ch2, dim1, dim2, phase, limp, fout;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, fresp, rstreg, exp_v;
  logic [2:0]  f1 = 3'h0, f2 = 3'h0;
  logic [3:0]  tap;
  logic [7:0]  q[$];
  logic [31:0] lfsr = 32'h4804;
  int          error_cnt = 0, checks = 0, cyc = 0;
  logic [5:0]  ra[5] = '{6'h00, 6'h01, 6'h02, 6'h2e, 6'h3f};
  logic [7:0]  rx[5] = '{8'h10, 8'h00, 8'h08, 8'h00, 8'h00};

  always #5 clk_in = ~clk_in;

  host_model h (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .data_out(wdata));
  system_config_regs dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wdata), .fault_active_in(fa),
    .fault_set_in(fs), .chan1_fault_in(f1), .chan2_fault_in(f2), .rd_data_out(rdata),
    .chan1_enable_out(ch1), .chan2_enable_out(ch2), .chan1_internal_dim_out(dim1),
    .chan2_internal_dim_out(dim2), .dim_phase_select_out(phase), .limp_home_out(limp),
    .fault_output_on_out(fout), .fault_response_out(fresp), .watchdog_tap_out(tap),
    .device_reset_reg_out(rstreg));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    h.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    q.push_back(e);
    h.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Read data lands one edge after the read strobe
  always @(posedge clk_in)
  begin
    rv <= rd_en;
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  always @(negedge clk_in)
    if (rv)
    begin
      exp_v = q.pop_front();
      `CHK(rdata, exp_v)
    end

  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (ra[i])
      rd(ra[i], rx[i]);
    $display("test reset_values done");
    // Dim inputs sit outside this block, taken as held high here
    wr(6'h00, 8'hcf);
    @(negedge clk_in);
    `CHK({phase, dim2, ch2, dim1, ch1}, 5'h1f)
    rd(6'h00, 8'h4f);
    wr(6'h00, 8'h00);
    @(negedge clk_in);
    `CHK({phase, dim2, ch2, dim1, ch1}, 5'h00)
    $display("test channel_config done");
    repeat (4)
    begin
      lfsr = next_rand(lfsr);
      wr(6'h2e, lfsr[7:0]);
      rd(6'h2e, lfsr[7:0]);
      wr(6'h02, lfsr[15:8]);
      @(negedge clk_in);
      `CHK(tap, lfsr[11:8])
      rd(6'h02, {4'h0, lfsr[11:8]});
      wr(6'h01, lfsr[23:16]);
      @(negedge clk_in);
      `CHK(fresp, lfsr[23:16])
      rd(6'h01, lfsr[23:16]);
    end
    $display("test random_rw done");
    wr(6'h00, 8'h20);
    repeat (20) @(posedge clk_in);
    rd(6'h00, 8'h20);
    wr(6'h00, 8'h00);
    @(negedge clk_in);
    `CHK(limp, 1'b0)
    $display("test limp_home done");
    @(posedge clk_in);
    fs <= 1'b1;
    fa <= 1'b1;
    @(posedge clk_in);
    fs <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(6'h00, 8'h80);
    repeat (2) @(negedge clk_in);
    `CHK(fout, 1'b1)
    @(posedge clk_in);
    fa <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(6'h00, 8'h00);
    @(negedge clk_in);
    `CHK(fout, 1'b1)
    wr(6'h00, 8'h80);
    @(negedge clk_in);
    `CHK(fout, 1'b0)
    $display("test fault_output done");
    wr(6'h01, 8'h24);
    wr(6'h00, 8'h05);
    @(posedge clk_in);
    f1 <= 3'h4;
    f2 <= 3'h2;
    repeat (5) @(posedge clk_in);
    f1 <= 3'h0;
    f2 <= 3'h0;
    @(negedge clk_in);
    `CHK({ch2, ch1}, 2'b10)
    repeat (4) @(posedge clk_in);
    wr(6'h00, 8'h05);
    @(negedge clk_in);
    `CHK({ch2, ch1}, 2'b11)
    $display("test latched_fault done");
    wr(6'h02, 8'h00);
    wr(6'h00, 8'h10);
    for (int i = 0; i < 70000 && limp !== 1'b1; i++)
      @(posedge clk_in);
    rd(6'h00, 8'h30);
    repeat (2) @(negedge clk_in);
    $display("test watchdog done");
    // Mid-run reset must restore the defaults, limp-home included
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(6'h00, 8'h10);
    @(negedge clk_in);
    `CHK(tap, 4'h8)
    @(negedge clk_in);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule : test_system_config_regs
`default_nettype wire
